// ---- src/adc_reset_and_early_halt.v ----
/*
  Successive-approximation sequencer for the 12-bit converter: acquisition,
  amplifier settling, MSB-first resolution, early halt through go/done and
  write-back of the two result bytes.
  Assumes one core clock. Control inputs come from logic on that clock; the
  comparator answer on COMP_I is analog and is filtered here before use.
*/
`timescale 1ns/10ps
`include "adc_ctrl_defines.vh"
module adc_reset_and_early_halt (
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  input  wire        ENABLE_I,
  input  wire        GO_SET_I,
  input  wire        GO_CLEAR_I,
  input  wire        COMP_I,
  output wire        GO_DONE_O,
  output reg         DONE_O,
  output reg         CONV_ON_O,
  output reg  [11:0] TRIAL_O,
  output reg  [7:0]  RESULT_HIGH_BYTE_O,
  output reg  [7:0]  RESULT_LOW_BYTE_O
);
  // Sequencer states
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_ACQ    = 2'h1;
  localparam [1:0] ST_SETTLE = 2'h2;
  localparam [1:0] ST_CONV   = 2'h3;

  reg  [1:0]            state;
  reg  [1:0]            next_state;
  reg  [`TAD_DIV_W-1:0] div;
  reg  [`BITCNT_W-1:0]  cnt;
  reg  [`BITCNT_W-1:0]  next_cnt;
  reg  [`RES_BITS-1:0]  sar;
  reg  [`RES_BITS-1:0]  next_sar;
  reg                   go;
  reg                   next_go;
  reg                   next_done;
  reg                   result_we;
  reg  [`RES_BITS-1:0]  result_val;
  reg                   comp_s1;
  reg                   comp_s2;
  reg                   comp_s3;
  reg                   comp_filt;
  wire                  tad_tick;
  wire                  conv_phase;
  wire                  start_req;
  wire                  halt_req;
  wire                  last_bit;
  wire                  acq_last;
  wire [`RES_BITS-1:0]  bit_mask;
  wire [`RES_BITS-1:0]  resolved;
  wire [`RES_BITS-1:0]  halted;

  // One bit period ends on this cycle
  assign tad_tick   = (div == `TAD_LAST);
  assign conv_phase = (state == ST_CONV);
  assign start_req  = GO_SET_I && ENABLE_I;
  assign halt_req   = GO_CLEAR_I && (state != ST_IDLE);
  assign last_bit   = (cnt == `CNT_LAST);
  assign acq_last   = (cnt == `ACQ_LAST);

  // Trial bit walks down from the top
  assign bit_mask = `MSB_TRIAL >> cnt;

  // Comparator low drops the trial bit, high keeps it
  assign resolved = comp_filt ? sar : (sar & ~bit_mask);

  // Trial bit not yet judged, lower bits still zero
  assign halted = sar & ~bit_mask;

  assign GO_DONE_O = go;

  // Analog comparator is asynchronous: three stages, accept on agreement
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      comp_s1   <= `COMP_RST;
      comp_s2   <= `COMP_RST;
      comp_s3   <= `COMP_RST;
      comp_filt <= `COMP_RST;
    end else begin
      comp_s1 <= COMP_I;
      comp_s2 <= comp_s1;
      comp_s3 <= comp_s2;
      if (comp_s2 == comp_s3) begin
        comp_filt <= comp_s3;
      end
    end
  end

  // Bit-period divider, only runs while busy
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div <= {`TAD_DIV_W{1'b0}};
    end else if (state == ST_IDLE || tad_tick) begin
      div <= {`TAD_DIV_W{1'b0}};
    end else begin
      div <= div + `TAD_ONE;
    end
  end

  // Next-state logic
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_sar   = sar;
    next_go    = go;
    next_done  = 1'b0;
    result_we  = 1'b0;
    result_val = resolved;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_go    = 1'b1;
          next_state = ST_ACQ;
          next_cnt   = {`BITCNT_W{1'b0}};
        end
      end
      ST_ACQ: begin
        // Fixed length, whatever resolution is kept later
        if (tad_tick) begin
          if (acq_last) begin
            next_state = ST_SETTLE;
            next_cnt   = {`BITCNT_W{1'b0}};
          end else begin
            next_cnt = cnt + `CNT_ONE;
          end
        end
      end
      ST_SETTLE: begin
        // One extra period for amplifier settling
        if (tad_tick) begin
          next_state = ST_CONV;
          next_sar   = `MSB_TRIAL;
        end
      end
      ST_CONV: begin
        if (tad_tick) begin
          if (last_bit) begin
            result_we  = 1'b1;
            next_go    = 1'b0;
            next_done  = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_sar = resolved | (bit_mask >> 1);
            next_cnt = cnt + `CNT_ONE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Software clear wins over a completion in the same cycle
    if (halt_req) begin
      next_go    = 1'b0;
      next_state = ST_IDLE;
      // Abort before conversion leaves results alone and signals nothing
      if (conv_phase) begin
        result_we  = 1'b1;
        result_val = halted;
        next_done  = 1'b1;
      end
    end
    // Converter off abandons a run, but a completion or clear due in the same cycle still writes and signals done
    if (!ENABLE_I) begin
      next_go    = 1'b0;
      next_state = ST_IDLE;
    end
  end

  // Sequencer state; reset abandons a run with no completion
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      cnt   <= {`BITCNT_W{1'b0}};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Trial code register and its output copy
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sar     <= {`RES_BITS{1'b0}};
      TRIAL_O <= {`RES_BITS{1'b0}};
    end else begin
      sar     <= next_sar;
      TRIAL_O <= next_sar;
    end
  end

  // Flags seen by software
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      go        <= 1'b0;
      DONE_O    <= 1'b0;
      CONV_ON_O <= 1'b0;
    end else begin
      go        <= next_go;
      DONE_O    <= next_done;
      CONV_ON_O <= ENABLE_I;
    end
  end

  // Result bytes have no reset: kept across device reset, unknown at power-on
  always @(posedge CORE_CLK_I) begin
    if (RST_N_I && result_we) begin
      RESULT_HIGH_BYTE_O <= {`RES_HIGH_PAD, result_val[11:8]};
      RESULT_LOW_BYTE_O  <= result_val[7:0];
    end
  end
endmodule

// ---- pkg/adc_ctrl_defines.vh ----
/*
  Constants for the converter reset and early-halt control block.
  Assumes a single core clock at 250 MHz and a bit-period divider inside the block.
*/
// Functional notes
// - Device reset returns all converter control state to reset values, converter off.
// - Reset abandons a running conversion; no completion is signalled for it.
// - Reset leaves both result byte registers unchanged.
// - Result bytes are undefined after power-on until a conversion writes them.
// - Acquisition time is the same whatever resolution is finally converted.
// - Full conversion gives 12 bits; clearing go/done stops at once, keeping resolved bits.
// - Unresolved bits of a halted conversion are written as zero.
// - N bits take N bit periods plus one settling bit period.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define RES_BITS        12
`define BITCNT_W        4
`define TAD_DIV         8'h20
`define TAD_DIV_W       8
`define ACQ_TADS        4'h4
`define ACQ_LAST        4'h3
`define CNT_LAST        4'hB
`define CNT_ONE         4'h1
`define TAD_LAST        8'h1F
`define TAD_ONE         8'h01
`define MSB_TRIAL       12'h800
`define RES_HIGH_PAD    4'h0
`define COMP_RST        1'b0
`endif

// ---- tb/adc_halt_sva.sv ----
/* Port checker for the converter sequencer. Bound at the foot; sees only the top-level ports. */
`timescale 1ns/10ps
module adc_halt_sva (
  input logic        CORE_CLK_I, RST_N_I, ENABLE_I, GO_SET_I, GO_CLEAR_I, COMP_I,
  input logic        GO_DONE_O, DONE_O, CONV_ON_O,
  input logic [11:0] TRIAL_O,
  input logic [7:0]  RESULT_HIGH_BYTE_O, RESULT_LOW_BYTE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_start;
    GO_SET_I && ENABLE_I && !GO_DONE_O && !GO_CLEAR_I;
  endsequence
  // Reset itself is the case under test here
  a_rst_idle: assert property (disable iff (1'b0) !RST_N_I |=> !DONE_O && !GO_DONE_O && !CONV_ON_O && TRIAL_O == 12'h000)
    else $error("not idle in reset");
  a_start_go: assert property (s_start |=> GO_DONE_O)
    else $error("start not taken");
  a_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");
  a_done_ends: assert property (DONE_O |-> !GO_DONE_O)
    else $error("go flag high at done");
  a_clear_halts: assert property (GO_CLEAR_I && GO_DONE_O |=> !GO_DONE_O)
    else $error("clear did not halt");
  a_min_time: assert property (DONE_O |-> $past(GO_DONE_O, 150))
    else $error("done too early");
  a_res_hold: assert property (!$stable({RESULT_HIGH_BYTE_O, RESULT_LOW_BYTE_O}) |-> DONE_O)
    else $error("result changed without done");
  a_off_idle: assert property (!ENABLE_I |=> !GO_DONE_O && !CONV_ON_O)
    else $error("busy while off");
endmodule
bind adc_reset_and_early_halt adc_halt_sva u_sva (.*);

// ---- tb/adc_reset_and_early_halt_tb_top.sv ----
/* Self-checking bench for the converter sequencer. Drives the ports itself; comparator answers 1. */
`timescale 1ns/10ps
module adc_reset_and_early_halt_tb_top;
  logic       clk = 0, rst_n = 0, en = 0, go_set = 0, go_clr = 0, comp = 1;
  wire        go_done, done, conv_on;
  wire [11:0] trial;
  wire [7:0]  res_h, res_l;
  int         n_mismatch = 0, tests_run = 0, cyc = 0, n;
  adc_reset_and_early_halt u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ENABLE_I(en), .GO_SET_I(go_set),
    .GO_CLEAR_I(go_clr), .COMP_I(comp), .GO_DONE_O(go_done), .DONE_O(done), .CONV_ON_O(conv_on),
    .TRIAL_O(trial), .RESULT_HIGH_BYTE_O(res_h), .RESULT_LOW_BYTE_O(res_l));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic start_go(int wait_n);
    @(posedge clk) go_set <= 1;
    @(posedge clk) go_set <= 0;
    repeat (wait_n) @(posedge clk);
  endtask
  // Full run: 4 acquisition + 1 settle + 12 bit periods of 32 cycles
  task automatic t_full;
    start_go(0);
    n = 0;
    while (done !== 1'b1 && n < 700) begin
      @(posedge clk);
      #1 n++;
    end
    check("cycles", n >= 543 && n <= 547, 1);
    check("result", {res_h, res_l}, 32'h0000_0fff);
    check("conv on", conv_on, 1);
  endtask
  // Halt mid fifth bit: four upper bits kept, rest zero
  task automatic t_halt;
    start_go(300);
    go_clr <= 1;
    @(posedge clk) go_clr <= 0;
    #1 check("halt done", {go_done, done, trial}, 32'h0000_1f80);
    @(posedge clk);
    #1 check("halted", {go_done, done, res_h, res_l}, 32'h0000_0f00);
  endtask
  // Converter switched off mid-conversion: abandoned, results kept
  task automatic t_off;
    start_go(200);
    en <= 0;
    repeat (2) @(posedge clk);
    #1 check("off", {go_done, conv_on, done, res_h, res_l}, 32'h0000_0f00);
    @(posedge clk) en <= 1;
    @(posedge clk);
  endtask
  // Clear during acquisition: abort with no completion
  task automatic t_acq_clear;
    start_go(50);
    go_clr <= 1;
    @(posedge clk) go_clr <= 0;
    #1 check("acq clear", {go_done, done, res_h, res_l}, 32'h0000_0f00);
  endtask
  task automatic t_reset;
    start_go(300);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    #1 check("in reset", {done, go_done, conv_on, res_h, res_l}, 32'h0000_0f00);
    @(posedge clk) rst_n <= 1;
    repeat (600) @(posedge clk);
    #1 check("kept", {done, res_h, res_l}, 32'h0000_0f00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    en <= 1;
    t_full();
    t_halt();
    t_off();
    t_acq_clear();
    t_reset();
    end_sim();
  end
endmodule
